// File: include/jsc_cfg.svh
// constants for the scan data chains
`ifndef JSC_CFG_SVH
`define JSC_CFG_SVH

// instruction codes
`define JSC_IR_LEN         4
`define JSC_IR_EXTEST      4'h0
`define JSC_IR_INTEST      4'h1
`define JSC_IR_SAMPLE      4'h2
`define JSC_IR_ABORT       4'h8
`define JSC_IR_DP_ACCESS   4'hA
`define JSC_IR_AP_ACCESS   4'hB
`define JSC_IR_IDENT       4'hE
`define JSC_IR_BYPASS      4'hF
`define JSC_IR_CAPTURE     4'h1

// chain lengths and captured constants
`define JSC_ID_LEN         32
`define JSC_DBG_LEN        35
`define JSC_KIND_LEN       2
`define JSC_BYPASS_CAPTURE 1'b0
`define JSC_ABORT_CAPTURE  35'h0_0000_0000

// identification value: arbitrary, lsb must stay 1
`define JSC_ID_VALUE       32'h0000_1001

// sizes
`define JSC_NPAD           8
`define JSC_FIFO_DEPTH     4

// boundary cell order within one pin
`define JSC_CELL_IN        0
`define JSC_CELL_OUT       1
`define JSC_CELL_OE        2
`define JSC_CELLS_PER_PIN  3

`endif

// File: include/jsc_pkg.sv
// types shared by the scan data chain modules
package jsc_pkg;

  // test access port states, standard binary codes
  typedef enum logic [3:0] {
    JSC_TLR      = 4'hF,
    JSC_RTI      = 4'hC,
    JSC_SEL_DR   = 4'h7,
    JSC_CAP_DR   = 4'h6,
    JSC_SHIFT_DR = 4'h2,
    JSC_EX1_DR   = 4'h1,
    JSC_PAUSE_DR = 4'h3,
    JSC_EX2_DR   = 4'h0,
    JSC_UPD_DR   = 4'h5,
    JSC_SEL_IR   = 4'h4,
    JSC_CAP_IR   = 4'hE,
    JSC_SHIFT_IR = 4'hA,
    JSC_EX1_IR   = 4'h9,
    JSC_PAUSE_IR = 4'hB,
    JSC_EX2_IR   = 4'h8,
    JSC_UPD_IR   = 4'hD
  } jsc_tap_type;

  // data chain placed between serial in and out
  typedef enum logic [1:0] {
    JSC_CH_BOUNDARY = 2'h0,
    JSC_CH_IDENT    = 2'h1,
    JSC_CH_BYPASS   = 2'h2,
    JSC_CH_DEBUG    = 2'h3
  } jsc_chain_type;

endpackage

// File: include/jsc_stream_if.sv
// valid/ready word stream between the chain logic and its queue
`timescale 1ns/1ns
`default_nettype none
interface jsc_stream_if #(
  parameter int WIDTH = 37
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: design/jsc_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none
module jsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } jsc_sync_state_type;

  jsc_sync_state_type st;
  jsc_sync_state_type next_st;

  always_comb begin
    next_st = st;
    if (clk_en) begin
      next_st.stage1 = async_in;
      next_st.stage2 = st.stage1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule
`default_nettype wire

// File: design/jsc_fifo.sv
// small request queue with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
`include "jsc_cfg.svh"
module jsc_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = `JSC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   sys_rst,
  input  wire logic   clk_en,
  // streams
  jsc_stream_if.snk   fill,
  jsc_stream_if.src   drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [CW-1:0]               count;
  } jsc_fifo_state_type;

  jsc_fifo_state_type st;
  jsc_fifo_state_type next_st;
  logic               push;
  logic               pop;

  assign fill.ready  = clk_en && (st.count != CW'(DEPTH));
  assign drain.valid = clk_en && (st.count != '0);
  assign drain.data  = st.mem[st.rptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wptr] = fill.data;
      next_st.wptr = (st.wptr == PW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = (st.rptr == PW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// File: design/jsc_scan_chains.sv
// instruction-selected data chains of the test access port
// Contract
// - sample/preload routes boundary chain, captures pads
// - shift-dr shifts samples out, preload in
// - update-dr loads boundary holding registers
// - boundary capture on rising test clock
// - external/internal test drive held values
// - abort chain pushes clear/abort requests
// - debug-port chain requests, returns read data
// - access-port chain requests to internal buses
// - three debug chains are 35 bits
// - identification instruction after any reset
// - identification chain 32 bits, lsb one
// - identification captures fixed identity value
// - bypass is a single shift stage
// - bypass stage captures zero
// - pins give input, output, enable cells
// - reset pin has input cell only
// - exactly six selectable data chains
// - four-bit instruction codes as listed
// - unassigned codes act as bypass
`timescale 1ns/1ns
`default_nettype none
`include "jsc_cfg.svh"
module jsc_scan_chains #(
  parameter int          NPAD     = `JSC_NPAD,
  parameter int          DEPTH    = `JSC_FIFO_DEPTH,
  parameter logic [31:0] ID_VALUE = `JSC_ID_VALUE
) (
  // clock, reset, enable
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // test port pins
  input  wire logic                   tck,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  input  wire logic                   trst_n,
  output logic                        tdo,
  output logic                        tdo_oe,
  // pad ring
  input  wire logic [NPAD-1:0]        pad_in,
  input  wire logic                   rst_pin_n,
  output logic      [NPAD-1:0]        pad_out,
  output logic      [NPAD-1:0]        pad_oe,
  // core side
  input  wire logic [NPAD-1:0]        core_out,
  input  wire logic [NPAD-1:0]        core_oe,
  output logic      [NPAD-1:0]        core_in,
  // debug access port requests
  output logic                        dap_req_valid,
  input  wire logic                   dap_req_ready,
  output logic      [`JSC_KIND_LEN-1:0] dap_req_kind,
  output logic      [`JSC_DBG_LEN-1:0]  dap_req_data,
  // debug access port responses
  input  wire logic                   dap_rsp_valid,
  input  wire logic [`JSC_DBG_LEN-1:0]  dap_rsp_data
);
  localparam int BSR_LEN = `JSC_CELLS_PER_PIN * NPAD + 1;
  localparam int SHW     = (BSR_LEN > `JSC_DBG_LEN) ? BSR_LEN : `JSC_DBG_LEN;
  localparam int REQW    = `JSC_KIND_LEN + `JSC_DBG_LEN;
  localparam int IRW     = `JSC_IR_LEN;

  typedef struct packed {
    jsc_pkg::jsc_tap_type   tap;
    logic [IRW-1:0]         ir;
    logic [IRW-1:0]         ir_shift;
    logic [SHW-1:0]         shreg;
    logic [BSR_LEN-1:0]     hold;
    logic                   tck_prev;
    logic                   tdo;
    logic                   tdo_oe;
    logic                   pend;
    logic [REQW-1:0]        req;
    logic [`JSC_DBG_LEN-1:0] rsp;
    logic [NPAD-1:0]        pad_out;
    logic [NPAD-1:0]        pad_oe;
    logic [NPAD-1:0]        core_in;
  } jsc_top_state_type;

  jsc_top_state_type          st;
  jsc_top_state_type          next_st;
  logic [3:0]                 tap_pins;
  logic                       tck_s;
  logic                       tms_s;
  logic                       tdi_s;
  logic                       trst_s_n;
  logic [NPAD:0]              pads_s;
  logic                       rise;
  logic                       fall;
  logic                       stall;
  jsc_pkg::jsc_chain_type     sel;
  jsc_stream_if #(.WIDTH(REQW)) req_in ();
  jsc_stream_if #(.WIDTH(REQW)) req_out ();

  // pins cross into the system clock
  jsc_sync #(.WIDTH(4)) u_sync_tap (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({trst_n, tdi, tms, tck}),
    .sync_out (tap_pins)
  );

  jsc_sync #(.WIDTH(NPAD + 1)) u_sync_pad (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({rst_pin_n, pad_in}),
    .sync_out (pads_s)
  );

  jsc_fifo #(.WIDTH(REQW), .DEPTH(DEPTH)) u_req_fifo (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .fill    (req_in),
    .drain   (req_out)
  );

  assign tck_s    = tap_pins[0];
  assign tms_s    = tap_pins[1];
  assign tdi_s    = tap_pins[2];
  assign trst_s_n = tap_pins[3];

  // chain selection from the current instruction
  function automatic jsc_pkg::jsc_chain_type chain_of(input logic [IRW-1:0] code);
    case (code)
      `JSC_IR_EXTEST, `JSC_IR_INTEST, `JSC_IR_SAMPLE: chain_of = jsc_pkg::JSC_CH_BOUNDARY;
      `JSC_IR_ABORT, `JSC_IR_DP_ACCESS, `JSC_IR_AP_ACCESS: chain_of = jsc_pkg::JSC_CH_DEBUG;
      `JSC_IR_IDENT: chain_of = jsc_pkg::JSC_CH_IDENT;
      default: chain_of = jsc_pkg::JSC_CH_BYPASS;
    endcase
  endfunction

  // serial length of a chain
  function automatic int chain_len(input jsc_pkg::jsc_chain_type ch);
    case (ch)
      jsc_pkg::JSC_CH_BOUNDARY: chain_len = BSR_LEN;
      jsc_pkg::JSC_CH_IDENT:    chain_len = `JSC_ID_LEN;
      jsc_pkg::JSC_CH_DEBUG:    chain_len = `JSC_DBG_LEN;
      default:                  chain_len = 1;
    endcase
  endfunction

  // one kind of cell from every pin of the boundary vector
  function automatic logic [NPAD-1:0] cells(input logic [BSR_LEN-1:0] v, input int kind);
    logic [NPAD-1:0] r;
    r = '0;
    for (int p = 0; p < NPAD; p++) begin
      r[p] = v[`JSC_CELLS_PER_PIN * p + kind];
    end
    return r;
  endfunction

  // boundary image: per pin in, out, enable; reset pin input last
  function automatic logic [BSR_LEN-1:0] pack_bsr(input logic [NPAD-1:0] pin_in,
                                                  input logic [NPAD-1:0] pin_out,
                                                  input logic [NPAD-1:0] pin_oe,
                                                  input logic            rst_in);
    logic [BSR_LEN-1:0] v;
    v = '0;
    for (int p = 0; p < NPAD; p++) begin
      v[`JSC_CELLS_PER_PIN * p + `JSC_CELL_IN]  = pin_in[p];
      v[`JSC_CELLS_PER_PIN * p + `JSC_CELL_OUT] = pin_out[p];
      v[`JSC_CELLS_PER_PIN * p + `JSC_CELL_OE]  = pin_oe[p];
    end
    v[BSR_LEN-1] = rst_in;
    return v;
  endfunction

  // standard controller transitions
  function automatic jsc_pkg::jsc_tap_type tap_next(input jsc_pkg::jsc_tap_type s, input logic m);
    case (s)
      jsc_pkg::JSC_TLR:      tap_next = m ? jsc_pkg::JSC_TLR    : jsc_pkg::JSC_RTI;
      jsc_pkg::JSC_RTI:      tap_next = m ? jsc_pkg::JSC_SEL_DR : jsc_pkg::JSC_RTI;
      jsc_pkg::JSC_SEL_DR:   tap_next = m ? jsc_pkg::JSC_SEL_IR : jsc_pkg::JSC_CAP_DR;
      jsc_pkg::JSC_CAP_DR:   tap_next = m ? jsc_pkg::JSC_EX1_DR : jsc_pkg::JSC_SHIFT_DR;
      jsc_pkg::JSC_SHIFT_DR: tap_next = m ? jsc_pkg::JSC_EX1_DR : jsc_pkg::JSC_SHIFT_DR;
      jsc_pkg::JSC_EX1_DR:   tap_next = m ? jsc_pkg::JSC_UPD_DR : jsc_pkg::JSC_PAUSE_DR;
      jsc_pkg::JSC_PAUSE_DR: tap_next = m ? jsc_pkg::JSC_EX2_DR : jsc_pkg::JSC_PAUSE_DR;
      jsc_pkg::JSC_EX2_DR:   tap_next = m ? jsc_pkg::JSC_UPD_DR : jsc_pkg::JSC_SHIFT_DR;
      jsc_pkg::JSC_UPD_DR:   tap_next = m ? jsc_pkg::JSC_SEL_DR : jsc_pkg::JSC_RTI;
      jsc_pkg::JSC_SEL_IR:   tap_next = m ? jsc_pkg::JSC_TLR    : jsc_pkg::JSC_CAP_IR;
      jsc_pkg::JSC_CAP_IR:   tap_next = m ? jsc_pkg::JSC_EX1_IR : jsc_pkg::JSC_SHIFT_IR;
      jsc_pkg::JSC_SHIFT_IR: tap_next = m ? jsc_pkg::JSC_EX1_IR : jsc_pkg::JSC_SHIFT_IR;
      jsc_pkg::JSC_EX1_IR:   tap_next = m ? jsc_pkg::JSC_UPD_IR : jsc_pkg::JSC_PAUSE_IR;
      jsc_pkg::JSC_PAUSE_IR: tap_next = m ? jsc_pkg::JSC_EX2_IR : jsc_pkg::JSC_PAUSE_IR;
      jsc_pkg::JSC_EX2_IR:   tap_next = m ? jsc_pkg::JSC_UPD_IR : jsc_pkg::JSC_SHIFT_IR;
      jsc_pkg::JSC_UPD_IR:   tap_next = m ? jsc_pkg::JSC_SEL_DR : jsc_pkg::JSC_RTI;
      default:               tap_next = jsc_pkg::JSC_TLR;
    endcase
  endfunction

  assign sel   = chain_of(st.ir);
  assign rise  = tck_s & ~st.tck_prev;
  assign fall  = ~tck_s & st.tck_prev;
  // a full queue holds back test clock edges until a slot frees
  assign stall = st.pend & ~req_in.ready;

  assign req_in.valid  = st.pend;
  assign req_in.data   = st.req;
  assign req_out.ready = dap_req_ready;

  always_comb begin
    next_st = st;
    if (clk_en) begin
      if (dap_rsp_valid) begin
        next_st.rsp = dap_rsp_data;
      end
      if (st.pend && req_in.ready) begin
        next_st.pend = 1'b0;
      end
      if (!stall) begin
        next_st.tck_prev = tck_s;
      end
      // pad and core paths
      if (st.ir == `JSC_IR_EXTEST) begin
        next_st.pad_out = cells(st.hold, `JSC_CELL_OUT);
        next_st.pad_oe  = cells(st.hold, `JSC_CELL_OE);
      end else begin
        next_st.pad_out = core_out;
        next_st.pad_oe  = core_oe;
      end
      if (st.ir == `JSC_IR_INTEST) begin
        next_st.core_in = cells(st.hold, `JSC_CELL_IN);
      end else begin
        next_st.core_in = pads_s[NPAD-1:0];
      end
      if (rise && !stall) begin
        next_st.tap = tap_next(st.tap, tms_s);
        case (st.tap)
          jsc_pkg::JSC_CAP_DR: begin
            case (sel)
              jsc_pkg::JSC_CH_BOUNDARY: begin
                next_st.shreg[BSR_LEN-1:0] = pack_bsr(pads_s[NPAD-1:0], st.pad_out, st.pad_oe,
                                                      pads_s[NPAD]);
              end
              jsc_pkg::JSC_CH_IDENT: begin
                next_st.shreg[`JSC_ID_LEN-1:0] = ID_VALUE;
              end
              jsc_pkg::JSC_CH_DEBUG: begin
                next_st.shreg[`JSC_DBG_LEN-1:0] =
                  (st.ir == `JSC_IR_ABORT) ? `JSC_ABORT_CAPTURE : st.rsp;
              end
              default: begin
                next_st.shreg[0] = `JSC_BYPASS_CAPTURE;
              end
            endcase
          end
          jsc_pkg::JSC_SHIFT_DR: begin
            next_st.shreg = st.shreg >> 1;
            next_st.shreg[chain_len(sel) - 1] = tdi_s;
          end
          jsc_pkg::JSC_UPD_DR: begin
            if (sel == jsc_pkg::JSC_CH_BOUNDARY) begin
              next_st.hold = st.shreg[BSR_LEN-1:0];
            end
            if (sel == jsc_pkg::JSC_CH_DEBUG) begin
              next_st.pend = 1'b1;
              next_st.req  = {st.ir[`JSC_KIND_LEN-1:0], st.shreg[`JSC_DBG_LEN-1:0]};
            end
          end
          jsc_pkg::JSC_CAP_IR: begin
            next_st.ir_shift = `JSC_IR_CAPTURE;
          end
          jsc_pkg::JSC_SHIFT_IR: begin
            next_st.ir_shift = {tdi_s, st.ir_shift[IRW-1:1]};
          end
          jsc_pkg::JSC_UPD_IR: begin
            next_st.ir = st.ir_shift;
          end
          default: begin
          end
        endcase
      end
      if (fall && !stall) begin
        if (st.tap == jsc_pkg::JSC_SHIFT_DR) begin
          next_st.tdo    = st.shreg[0];
          next_st.tdo_oe = 1'b1;
        end else if (st.tap == jsc_pkg::JSC_SHIFT_IR) begin
          next_st.tdo    = st.ir_shift[0];
          next_st.tdo_oe = 1'b1;
        end else begin
          next_st.tdo_oe = 1'b0;
        end
      end
      if (!trst_s_n) begin
        next_st.tap = jsc_pkg::JSC_TLR;
      end
      if (st.tap == jsc_pkg::JSC_TLR) begin
        next_st.ir = `JSC_IR_IDENT;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st     <= '0;
      st.tap <= jsc_pkg::JSC_TLR;
      st.ir  <= `JSC_IR_IDENT;
    end else begin
      st <= next_st;
    end
  end

  assign tdo           = st.tdo;
  assign tdo_oe        = st.tdo_oe;
  assign pad_out       = st.pad_out;
  assign pad_oe        = st.pad_oe;
  assign core_in       = st.core_in;
  assign dap_req_valid = req_out.valid;
  assign dap_req_kind  = req_out.data[REQW-1:`JSC_DBG_LEN];
  assign dap_req_data  = req_out.data[`JSC_DBG_LEN-1:0];

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_step(jsc_pkg::jsc_tap_type s, jsc_pkg::jsc_chain_type ch);
    clk_en && rise && !stall && trst_s_n && st.tap == s && sel == ch;
  endsequence

  sequence s_fall_shift;
    clk_en && fall && !stall && st.tap == jsc_pkg::JSC_SHIFT_DR;
  endsequence

  a_ident_after_tlr: assert property ((clk_en && st.tap == jsc_pkg::JSC_TLR) |=> st.ir == `JSC_IR_IDENT)
    else $error("instruction not identification after reset state");

  a_trst_forces_tlr: assert property ((clk_en && !trst_s_n) |=> st.tap == jsc_pkg::JSC_TLR ##1
                                      (!clk_en || st.ir == `JSC_IR_IDENT))
    else $error("test reset did not reach reset state");

  a_ident_capture: assert property (s_step(jsc_pkg::JSC_CAP_DR, jsc_pkg::JSC_CH_IDENT) |=>
                                    st.shreg[`JSC_ID_LEN-1:0] == ID_VALUE && st.shreg[0])
    else $error("identification capture wrong");

  a_bypass_capture: assert property (s_step(jsc_pkg::JSC_CAP_DR, jsc_pkg::JSC_CH_BYPASS) |=>
                                     st.shreg[0] == 1'b0)
    else $error("bypass stage did not capture zero");

  a_reserved_bypass: assert property ((st.ir inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD}) |->
                                      sel == jsc_pkg::JSC_CH_BYPASS)
    else $error("unassigned code not mapped to bypass");

  a_bsr_reset_cell: assert property (s_step(jsc_pkg::JSC_CAP_DR, jsc_pkg::JSC_CH_BOUNDARY) |=>
                                     st.shreg[BSR_LEN-1] == $past(pads_s[NPAD]))
    else $error("reset pin cell not captured");

  a_bsr_update: assert property (s_step(jsc_pkg::JSC_UPD_DR, jsc_pkg::JSC_CH_BOUNDARY) |=>
                                 st.hold == $past(st.shreg[BSR_LEN-1:0]))
    else $error("holding registers not updated");

  a_extest_drive: assert property ((clk_en && st.ir == `JSC_IR_EXTEST) |=>
                                   pad_out == cells($past(st.hold), `JSC_CELL_OUT))
    else $error("external test does not drive held outputs");

  a_debug_push: assert property (s_step(jsc_pkg::JSC_UPD_DR, jsc_pkg::JSC_CH_DEBUG) |=>
                                 st.pend && st.req[`JSC_DBG_LEN-1:0] == $past(st.shreg[`JSC_DBG_LEN-1:0]))
    else $error("debug request not queued");

  a_tdo_falling: assert property (s_fall_shift |=> tdo_oe && tdo == $past(st.shreg[0]))
    else $error("serial output not taken from chain lsb");

  a_shift_insert: assert property (s_step(jsc_pkg::JSC_SHIFT_DR, jsc_pkg::JSC_CH_DEBUG) |=>
                                   st.shreg[`JSC_DBG_LEN-1] == $past(tdi_s))
    else $error("serial input not entering at chain end");
endmodule
`default_nettype wire

// File: tb/jsc_tester.sv
// test port master model: drives the link pins and scans chains
`timescale 1ns/1ns
`default_nettype none
module jsc_tester (
  // test port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // one test clock period, tck stands low between frames
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62;
    q = tdo;
    tck = 1'b1;
    #63;
    tck = 1'b0;
  endtask
  // five mode highs reach test-logic-reset, then idle
  task automatic idle();
    logic q;
    for (int i = 0; i < 6; i++) step(i < 5, 1'b0, q);
  endtask
  // instruction or data scan from idle to idle, lsb first
  task automatic scan(input bit ir, input logic [63:0] din, input int n, output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking testbench for the scan data chains
`timescale 1ns/1ns
`default_nettype none
`include "jsc_cfg.svh"
module tb;
  logic        clk_sys, sys_rst, clk_en, tck, tms, tdi, trst_n, tdo, tdo_oe, rst_pin_n;
  logic [7:0]  pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
  logic        dap_req_valid, dap_req_ready, dap_rsp_valid;
  logic [1:0]  dap_req_kind;
  logic [34:0] dap_req_data, dap_rsp_data;
  logic [63:0] d;
  int          n_mismatch, n_compared, cyc;

  jsc_scan_chains u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .rst_pin_n(rst_pin_n),
    .pad_out(pad_out), .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .dap_req_valid(dap_req_valid), .dap_req_ready(dap_req_ready), .dap_req_kind(dap_req_kind),
    .dap_req_data(dap_req_data), .dap_rsp_valid(dap_rsp_valid), .dap_rsp_data(dap_rsp_data));
  jsc_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // load an instruction, its capture pattern comes back
  task automatic load_ir(input logic [3:0] code);
    u_tst.scan(1'b1, {60'h0, code}, 4, d);
    check(d[3:0], 4'h1);
  endtask

  task automatic t_ident();
    u_tst.scan(1'b0, '0, 32, d);
    check(d[31:0], `JSC_ID_VALUE);
    check(d[0], 1'b1);
  endtask

  // bypass and an unassigned code: one stage capturing zero
  task automatic t_bypass();
    logic [3:0] codes [2] = '{4'hF, 4'h5};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      u_tst.scan(1'b0, 64'h3, 2, d);
      check(d[1:0], 2'h2);
    end
  endtask

  task automatic t_boundary();
    logic [63:0] e, pl;
    logic [7:0]  hin, hout, hoe;
    hin = 8'h5A;
    hout = 8'hC3;
    hoe = 8'h0F;
    @(negedge clk_sys);
    pad_in = 8'hA5;
    core_out = 8'h3C;
    core_oe = 8'hF0;
    rst_pin_n = 1'b1;
    e = '0;
    e[24] = rst_pin_n;
    pl = '0;
    for (int p = 0; p < 8; p++) begin
      e[3*p] = pad_in[p];
      e[3*p+1] = core_out[p];
      e[3*p+2] = core_oe[p];
      pl[3*p] = hin[p];
      pl[3*p+1] = hout[p];
      pl[3*p+2] = hoe[p];
    end
    load_ir(4'h2);
    u_tst.scan(1'b0, pl, 25, d);
    check(d[24:0], e[24:0]);
    load_ir(4'h0);
    @(negedge clk_sys);
    check(pad_out, hout);
    check(pad_oe, hoe);
    load_ir(4'h1);
    @(negedge clk_sys);
    check(core_in, hin);
    check(pad_out, core_out);
    // a low enable freezes the pad path
    clk_en = 1'b0;
    core_out = 8'hC3;
    repeat (4) @(negedge clk_sys);
    check(pad_out, 8'h3C);
    clk_en = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(pad_out, 8'hC3);
  endtask

  // requests queue up while the consumer stalls, then drain in order
  task automatic t_debug();
    logic [3:0]  codes [4] = '{4'hA, 4'hB, 4'h8, 4'hA};
    logic [34:0] w;
    int          k;
    @(negedge clk_sys);
    dap_req_ready = 1'b0;
    foreach (codes[i]) begin
      load_ir(codes[i]);
      w = 35'h5_A5A5_0000 + 35'(i);
      u_tst.scan(1'b0, {29'h0, w}, 35, d);
    end
    foreach (codes[i]) begin
      k = 0;
      while (dap_req_valid !== 1'b1 && k < 50) begin
        @(negedge clk_sys);
        k++;
      end
      check(dap_req_kind, codes[i][1:0]);
      check(dap_req_data, 35'h5_A5A5_0000 + 35'(i));
      @(negedge clk_sys);
      dap_req_ready = 1'b1;
      @(negedge clk_sys);
      dap_req_ready = 1'b0;
    end
    repeat (3) @(negedge clk_sys);
    check(dap_req_valid, 1'b0);
    dap_req_ready = 1'b1;
    dap_rsp_data = 35'h2_AAAA_5555;
    dap_rsp_valid = 1'b1;
    @(negedge clk_sys);
    dap_rsp_valid = 1'b0;
    load_ir(4'hA);
    u_tst.scan(1'b0, '0, 35, d);
    check(d[34:0], 35'h2_AAAA_5555);
    load_ir(4'h8);
    u_tst.scan(1'b0, '0, 35, d);
    check(d[34:0], `JSC_ABORT_CAPTURE);
  endtask

  // test reset pin, then a mid-run system reset; each alone restores identification
  task automatic t_trst();
    logic q;
    for (int k = 0; k < 2; k++) begin
      load_ir(4'hF);
      @(negedge clk_sys);
      if (k == 0) u_tst.trst_n = 1'b0;
      else sys_rst = 1'b1;
      repeat (8) @(negedge clk_sys);
      u_tst.trst_n = 1'b1;
      sys_rst = 1'b0;
      u_tst.step(1'b0, 1'b0, q);
      t_ident();
    end
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    pad_in = 8'h00;
    core_out = 8'h00;
    core_oe = 8'h00;
    rst_pin_n = 1'b1;
    dap_req_ready = 1'b1;
    dap_rsp_valid = 1'b0;
    dap_rsp_data = 35'h0_0000_0000;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    u_tst.idle();
    t_ident();
    t_bypass();
    t_boundary();
    t_debug();
    t_trst();
    print_verdict();
  end
endmodule
`default_nettype wire
